// >>> src/dmcr_pkg.sv
// Constants, field layouts and carrier types of the decoder misc registers.
// Assumes an 8-bit register port with a byte address, on core_clk.
package dmcr_pkg;
    localparam logic [7:0] ADDR_CAPTION_DATA = 8'h1D;
    localparam logic [7:0] ADDR_WC_DOWN = 8'h1E;
    localparam logic [7:0] ADDR_SW_RESET = 8'h1F;
    localparam logic [7:0] ADDR_PROG_IO = 8'h3F;
    localparam logic [7:0] WC_DOWN_RESET = 8'h7F;
    localparam logic [7:0] PROG_IO_RESET = 8'h00;
    localparam logic [7:0] READ_UNDEFINED = 8'h00;
    localparam int NOISE_REJECT_BIT = 7;
    localparam int PER_FRAME_BIT = 6;
    localparam int STEP_LSB = 0;
    localparam int STEP_W = 6;
    localparam int IO_W = 4;
    localparam int IN_LSB = 4;
    localparam int SYNC_STAGES = 3;
    localparam int ACC_W = 16;
    localparam logic [3:0] OUT_FORCED = 4'hF;

    // Register port access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmcr_req_t;

    // Caption word from the line slicer
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } dmcr_caption_t;
endpackage

// >>> src/dmcr_sync.sv
// Input synchroniser chain for the asynchronous video data pins.
// Assumes pins come from outside core_clk.
// A change is accepted once stages 2 and 3 agree.
`timescale 1ns/1ns
module dmcr_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pins and result
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_sync
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    wire [W-1:0] agree = ~(s2_q ^ s3_q);
    wire [W-1:0] out_d = (agree & s3_q) | (~agree & out_q);

    // First stage is read only by the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= pin_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign pin_sync = out_q;
endmodule

// >>> src/dmcr_regs.sv
// Misc control register bank: caption byte, white crush down count,
// software reset trigger and programmable I/O on the low video pins.
// Assumes a one-cycle rd or wr strobe on core_clk, and field/frame
// events and caption words produced by decoder logic on the same clock.
`timescale 1ns/1ns
module dmcr_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire dmcr_pkg::dmcr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Decoder side
    input wire dmcr_pkg::dmcr_caption_t caption,
    input wire logic caption_next,
    input wire logic field_end,
    input wire logic frame_end,
    input wire logic [5:0] up_step_value,
    input wire logic output_width_select,
    output logic vertical_noise_reject,
    output logic [15:0] agc_reduction,
    output logic soft_reset,
    // Programmable I/O pins
    input wire logic [3:0] video_data_pins_in,
    output logic [3:0] video_data_pins_out,
    output logic [3:0] video_data_pins_oe_n
);
    logic [7:0] caption_q;
    logic [7:0] caption_d;
    logic caption_hi_q;
    logic [15:0] caption_word_q;
    logic [7:0] wc_down_q;
    logic [7:0] wc_down_d;
    logic [3:0] io_out_q;
    logic [3:0] io_out_d;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [15:0] acc_q;
    logic [15:0] acc_d;
    logic [15:0] agc_q;
    logic srst_q;
    logic noise_q;
    logic [3:0] pin_out_q;
    logic [3:0] pin_oe_n_q;
    logic [3:0] in_sync;

    dmcr_sync #(.W(dmcr_pkg::IO_W)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin_async(video_data_pins_in),
        .pin_sync(in_sync)
    );

    // Address decode
    wire hit_caption = req.addr == dmcr_pkg::ADDR_CAPTION_DATA;
    wire hit_wc = req.addr == dmcr_pkg::ADDR_WC_DOWN;
    wire hit_srst = req.addr == dmcr_pkg::ADDR_SW_RESET;
    wire hit_io = req.addr == dmcr_pkg::ADDR_PROG_IO;
    wire eight_bit = ~output_width_select;
    wire wr_wc = req.wr & hit_wc;
    wire wr_io = req.wr & hit_io & eight_bit;
    wire do_srst = req.wr & hit_srst;

    // Caption byte: low byte first, high byte on the next advance
    wire [7:0] cap_lo = caption.word[7:0];
    wire [7:0] cap_hi = caption_word_q[15:8];
    assign caption_d = caption.valid ? cap_lo :
                       (caption_next & ~caption_hi_q) ? cap_hi :
                       caption_q;

    assign wc_down_d = wr_wc ? req.wdata : wc_down_q;
    assign io_out_d = wr_io ? req.wdata[3:0] : io_out_q;

    // Down step: code 3F is -1, code 00 is -64, so step = code - 64
    // Ones above the code already make it code - 64 in two's complement
    wire [5:0] dn_code = wc_down_q[dmcr_pkg::STEP_LSB +: dmcr_pkg::STEP_W];
    wire [15:0] dn_step = {10'h3FF, dn_code};
    wire [15:0] up_step = {10'h000, up_step_value};
    wire per_frame = wc_down_q[dmcr_pkg::PER_FRAME_BIT];
    wire acc_tick = per_frame ? frame_end : field_end;
    assign acc_d = acc_tick ? acc_q + up_step + dn_step : acc_q;
    // Only net reduction is passed on; positive balance gives none
    wire [15:0] agc_d = acc_q[15] ? (~acc_q + 16'h0001) : 16'h0000;

    // Read mux; writes to caption and reads of reset address are benign
    wire [7:0] io_read = {in_sync, io_out_q};
    wire [7:0] rd_mux = hit_caption ? caption_q :
                        hit_wc ? wc_down_q :
                        hit_io ? io_read :
                        dmcr_pkg::READ_UNDEFINED;

    wire [3:0] pin_out_d = eight_bit ? io_out_q : dmcr_pkg::OUT_FORCED;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            caption_q <= 8'h00;
            caption_hi_q <= 1'b0;
            caption_word_q <= 16'h0000;
        end else begin
            caption_q <= caption_d;
            caption_word_q <= caption.valid ? caption.word : caption_word_q;
            caption_hi_q <= caption.valid ? 1'b0 :
                            caption_next ? 1'b1 : caption_hi_q;
        end
    end

    // Software reset returns command registers to defaults next edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wc_down_q <= dmcr_pkg::WC_DOWN_RESET;
            io_out_q <= dmcr_pkg::PROG_IO_RESET[3:0];
            acc_q <= 16'h0000;
        end else if (do_srst) begin
            wc_down_q <= dmcr_pkg::WC_DOWN_RESET;
            io_out_q <= dmcr_pkg::PROG_IO_RESET[3:0];
            acc_q <= 16'h0000;
        end else begin
            wc_down_q <= wc_down_d;
            io_out_q <= io_out_d;
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            agc_q <= 16'h0000;
            srst_q <= 1'b0;
            noise_q <= 1'b0;
            pin_out_q <= dmcr_pkg::OUT_FORCED;
            pin_oe_n_q <= 4'hF;
        end else begin
            rdata_q <= req.rd ? rd_mux : rdata_q;
            rvalid_q <= req.rd;
            agc_q <= agc_d;
            srst_q <= do_srst;
            noise_q <= wc_down_q[dmcr_pkg::NOISE_REJECT_BIT];
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= 4'h0;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign agc_reduction = agc_q;
    assign soft_reset = srst_q;
    assign vertical_noise_reject = noise_q;
    assign video_data_pins_out = pin_out_q;
    assign video_data_pins_oe_n = pin_oe_n_q;
endmodule

// >>> verif/dmcr_host.sv
// Host model: byte register reads and writes.
// Assumes the bench calls its tasks; drives on falling core_clk.
`timescale 1ns/1ns
module dmcr_host (
    // Clock
    input wire logic core_clk,
    // Register port
    output dmcr_pkg::dmcr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge core_clk);
        req.wr = 1'b0;
        req.wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        req.rd = 1'b0;
        // Data holds until next read, so a late look is safe
        for (int i = 0; i < 3 && rvalid !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        d = rdata;
    endtask
endmodule

// >>> verif/dmcr_regs_properties.sv
// Checker for the misc register bank ports.
// Assumes binding to dmcr_regs; one clock domain.
`timescale 1ns/1ns
module dmcr_regs_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched ports
    input wire dmcr_pkg::dmcr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic output_width_select,
    input wire logic vertical_noise_reject,
    input wire logic soft_reset,
    input wire logic [3:0] video_data_pins_out,
    input wire logic [3:0] video_data_pins_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence io_wr_s;
        req.wr && req.addr == 8'h3F && !output_width_select
        ##1 !req.wr && !output_width_select;
    endsequence
    sequence wc_wr_s;
        req.wr && req.addr == 8'h1E ##1 !req.wr;
    endsequence
    read_answer_a: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    reset_write_a: assert property (
        req.wr && req.addr == 8'h1F |=> soft_reset)
        else $error("no soft reset");
    read_no_reset_a: assert property (!req.wr |=> !soft_reset)
        else $error("stray soft reset");
    reset_read_a: assert property (
        req.rd && req.addr == 8'h1F |=> rdata == 8'h00)
        else $error("reset read data");
    out_forced_a: assert property (
        output_width_select |=> video_data_pins_out == 4'hF)
        else $error("outputs not forced");
    io_drive_a: assert property (
        io_wr_s |=> video_data_pins_out == $past(req.wdata[3:0], 2))
        else $error("pins not driven");
    pin_enable_a: assert property (
        1'b1 |=> video_data_pins_oe_n == 4'h0)
        else $error("pins not enabled");
    noise_bit_a: assert property (
        wc_wr_s |=> vertical_noise_reject == $past(req.wdata[7], 2))
        else $error("noise bit wrong");
endmodule
bind dmcr_regs dmcr_regs_properties u_props (.core_clk, .rst, .req, .rdata,
    .rvalid, .output_width_select, .vertical_noise_reject, .soft_reset,
    .video_data_pins_out, .video_data_pins_oe_n);

// >>> verif/dmcr_regs_bench.sv
// Bench for the misc register bank, driven through the host model.
// Assumes dmcr_pkg, dmcr_regs and dmcr_host are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module dmcr_regs_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    dmcr_pkg::dmcr_req_t req;
    dmcr_pkg::dmcr_caption_t caption = '0;
    logic cnext = 1'b0, field_end = 1'b0, frame_end = 1'b0, ows = 1'b0;
    logic [5:0] up = 6'h00;
    logic [3:0] pin_in = 4'h0, pin_out;
    logic [7:0] rdata, d, w;
    logic rvalid, noise;
    logic [15:0] agc;
    int failures = 0, tests_run = 0, cyc = 0;
    initial forever #5 core_clk = ~core_clk;
    dmcr_host u_host (.core_clk, .req, .rdata, .rvalid);
    dmcr_regs u_dut (.core_clk, .rst, .req, .rdata, .rvalid, .caption,
        .caption_next(cnext), .field_end, .frame_end, .up_step_value(up),
        .output_width_select(ows), .vertical_noise_reject(noise),
        .agc_reduction(agc), .soft_reset(), .video_data_pins_in(pin_in),
        .video_data_pins_out(pin_out), .video_data_pins_oe_n());
    task automatic test_done();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    function automatic logic [15:0] agc_exp(int c, int u);
        return 16'(64 - c - u);
    endfunction
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        w = 8'($urandom(40028));
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        u_host.rd(8'h1E, d); `CHK(d, 8'h7F)
        u_host.rd(8'h3F, d); `CHK(d[3:0], 4'h0)
        repeat (6) begin
            w = 8'($urandom);
            pin_in = w[7:4];
            u_host.wr(8'h1E, w);
            u_host.rd(8'h1E, d); `CHK(d, w)
            `CHK(noise, w[7])
            u_host.wr(8'h3F, w);
            repeat (6) @(negedge core_clk);
            `CHK(pin_out, w[3:0])
            u_host.rd(8'h3F, d); `CHK(d[7:4], w[7:4])
        end
        // Wide mode: input bits are not read back here
        ows = 1'b1;
        u_host.wr(8'h3F, ~w);
        `CHK(pin_out, 4'hF)
        ows = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(pin_out, w[3:0])
        caption = '{valid: 1'b1, word: 16'($urandom)};
        @(negedge core_clk);
        caption.valid = 1'b0;
        u_host.rd(8'h1D, d); `CHK(d, caption.word[7:0])
        pulse(cnext);
        u_host.wr(8'h1D, ~d);
        u_host.rd(8'h1D, d); `CHK(d, caption.word[15:8])
        u_host.rd(8'h1F, d); `CHK(d, 8'h00)
        u_host.rd(8'h1E, d); `CHK(d, w)
        u_host.wr(8'h1F, 8'($urandom));
        u_host.rd(8'h1E, d); `CHK(d, 8'h7F)
        u_host.rd(8'h3F, d); `CHK(d[3:0], 4'h0)
        w = 8'($urandom) & 8'h1F;
        up = 6'($urandom) & 6'h0F;
        u_host.wr(8'h1E, w | 8'h40);
        pulse(field_end);
        `CHK(agc, 16'h0000)
        pulse(frame_end);
        `CHK(agc, agc_exp(w, up))
        u_host.wr(8'h1F, 8'h00);
        u_host.wr(8'h1E, w);
        pulse(field_end);
        `CHK(agc, agc_exp(w, up))
        test_done();
    end
endmodule
